// >>> rtl/arf_defines.vh
// Constants for the converter result format and window detector block.
`ifndef ARF_DEFINES_VH
`define ARF_DEFINES_VH
// ----------------------------------------------------------------------
// Register word indices (byte address is four times the index).
// ----------------------------------------------------------------------
`define ARF_IDX_CTRL      3'h0
`define ARF_IDX_RES_HI    3'h1
`define ARF_IDX_RES_LO    3'h2
`define ARF_IDX_GT_HI     3'h3
`define ARF_IDX_GT_LO     3'h4
`define ARF_IDX_LT_HI     3'h5
`define ARF_IDX_LT_LO     3'h6
`define ARF_IDX_CFG       3'h7
// ----------------------------------------------------------------------
// Control and config register field positions.
// ----------------------------------------------------------------------
`define ARF_CTL_EN        7
`define ARF_CTL_TRK       6
`define ARF_CTL_DONE      5
`define ARF_CTL_BUSY      4
`define ARF_CTL_SRC_HI    3
`define ARF_CTL_SRC_LO    2
`define ARF_CTL_WIN       1
`define ARF_CTL_LJST      0
`define ARF_CFG_DIFF      0
// ----------------------------------------------------------------------
// Reset values.
// ----------------------------------------------------------------------
`define ARF_CTRL_RST      8'h00
`define ARF_LIMIT_RST     8'h00
`define ARF_SRC_SW        2'h0
// ----------------------------------------------------------------------
// Timing: conversion length in mclk cycles.
// ----------------------------------------------------------------------
`define ARF_CONV_CYCLES   8'h10
`endif

// >>> rtl/arf_formatter.v
// Result justification and sign extension.
`timescale 1ns/10ps
`include "arf_defines.vh"
module arf_formatter (
  // Raw result and mode
  input  wire [11:0] rawCode,
  input  wire        diffMode,
  input  wire        leftJustify,
  // Formatted word
  output reg  [15:0] dataWord
);
  always @* begin
    if (leftJustify) begin
      dataWord = {rawCode, 4'h0};
    end else if (diffMode) begin
      dataWord = {{4{rawCode[11]}}, rawCode};
    end else begin
      dataWord = {4'h0, rawCode};
    end
  end
endmodule // arf_formatter

// >>> rtl/arf_window.v
// Window comparison of a formatted result against two limit words.
`timescale 1ns/10ps
module arf_window (
  // Compared values
  input  wire [15:0] dataWord,
  input  wire [15:0] gtLimit,
  input  wire [15:0] ltLimit,
  input  wire        signedCmp,
  // Result
  output wire        hit
);
  wire [16:0] d;
  wire [16:0] g;
  wire [16:0] l;
  wire        above;
  wire        below;
  // Extend by one bit so signed and unsigned compares share one comparator.
  assign d = {signedCmp & dataWord[15], dataWord} ^ 17'h10000;
  assign g = {signedCmp & gtLimit[15], gtLimit} ^ 17'h10000;
  assign l = {signedCmp & ltLimit[15], ltLimit} ^ 17'h10000;
  assign above = d > g;
  assign below = d < l;
  assign hit = (l > g) ? (above & below) : (above | below);
endmodule // arf_window

// >>> rtl/arf_adc_ctrl.v
// Control, result registers and window detector of a 12-bit converter.
// ----------------------------------------------------------------------
// Summary of operation
// - With right justification the result fills the high byte low nibble and the low byte.
// - Right justified, the high byte top nibble is sign copies if differential, else zero.
// - With left justification the result fills the high byte and low byte top nibble.
// - Single-ended codes are unsigned 12-bit, differential codes signed 12-bit.
// - Differential codes are two's complement, for example 0xfc00 or 0xc000 at minus half.
// - Every new result is compared with both limit words with no software action.
// - A result meeting the window condition sets the window flag, usable as an interrupt.
// - The window flag stays readable and set until software clears it.
// - Inside or outside flagging is chosen only by how the two limits relate.
// - With the enable bit low the converter idles and ignores starts.
// ----------------------------------------------------------------------
`timescale 1ns/10ps
`include "arf_defines.vh"
module arf_adc_ctrl (
  // Clock and reset
  input  wire        mclk,
  input  wire        reset,
  input  wire        clkEn,
  // Avalon-MM slave
  input  wire [4:0]  avAddress,
  input  wire        avRead,
  input  wire        avWrite,
  input  wire [31:0] avWriteData,
  input  wire [3:0]  avByteEnable,
  output reg  [31:0] avReadData,
  output wire        avWaitRequest,
  // Converter core
  input  wire [11:0] sarCode,
  input  wire        externalConvertStart,
  input  wire        timerOverflow,
  output wire        converterPowerOn,
  output wire        windowCompareFlag,
  output wire        conversionDoneFlag
);
  // ----------------------------------------------------------------------
  // Registers.
  // ----------------------------------------------------------------------
  localparam ST_IDLE = 1'b0;
  localparam ST_CONV = 1'b1;
  reg        enable_r;
  reg        trackMode_r;
  reg        done_r;
  reg        busy_r;
  reg [1:0]  startSrc_r;
  reg        win_r;
  reg        ljst_r;
  reg        diff_r;
  reg [11:0] code_r;
  reg [7:0]  gtHi_r;
  reg [7:0]  gtLo_r;
  reg [7:0]  ltHi_r;
  reg [7:0]  ltLo_r;
  reg [7:0]  convCnt_r;
  reg        state_r;
  reg        newResult_r;
  reg        ack_r;
  reg [1:0]  extSync_r;
  reg        extPrev_r;
  reg [1:0]  tmrSync_r;
  reg        tmrPrev_r;
  wire [2:0]  regIdx;
  wire        wrCtl;
  wire        swStart;
  wire        extRise;
  wire        tmrRise;
  wire        startReq;
  wire        convEnd;
  wire [15:0] dataWord;
  wire        winHit;
  reg  [7:0]  rdByte;
  assign regIdx = avAddress[4:2];
  assign wrCtl  = avWrite & ack_r & avByteEnable[0] & (regIdx == `ARF_IDX_CTRL);
  assign converterPowerOn   = enable_r;
  assign windowCompareFlag  = win_r;
  assign conversionDoneFlag = done_r;
  // ----------------------------------------------------------------------
  // Bus handshake: one wait cycle, then the access completes.
  // ----------------------------------------------------------------------
  assign avWaitRequest = (avRead | avWrite) & ~ack_r;
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      ack_r <= 1'b0;
    end else if (clkEn) begin
      ack_r <= (avRead | avWrite) & ~ack_r;
    end
  end
  // ----------------------------------------------------------------------
  // Start sources, external pins synchronised first.
  // ----------------------------------------------------------------------
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      extSync_r <= 2'h0;
      extPrev_r <= 1'b0;
      tmrSync_r <= 2'h0;
      tmrPrev_r <= 1'b0;
    end else if (clkEn) begin
      extSync_r <= {extSync_r[0], externalConvertStart};
      extPrev_r <= extSync_r[1];
      tmrSync_r <= {tmrSync_r[0], timerOverflow};
      tmrPrev_r <= tmrSync_r[1];
    end
  end
  assign extRise = extSync_r[1] & ~extPrev_r;
  assign tmrRise = tmrSync_r[1] & ~tmrPrev_r;
  assign swStart = wrCtl & avWriteData[`ARF_CTL_BUSY];
  assign startReq = enable_r & (state_r == ST_IDLE) &
                    ((startSrc_r == `ARF_SRC_SW) ? swStart :
                     (startSrc_r == 2'h2) ? extRise : tmrRise);
  assign convEnd = (state_r == ST_CONV) & (convCnt_r == 8'h01);
  // ----------------------------------------------------------------------
  // Conversion sequencer.
  // ----------------------------------------------------------------------
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_r     <= ST_IDLE;
      convCnt_r   <= 8'h00;
      busy_r      <= 1'b0;
      code_r      <= 12'h000;
      newResult_r <= 1'b0;
    end else if (clkEn) begin
      newResult_r <= convEnd;
      case (state_r)
        ST_IDLE: begin
          if (startReq) begin
            state_r   <= ST_CONV;
            busy_r    <= 1'b1;
            convCnt_r <= `ARF_CONV_CYCLES;
          end
        end
        default: begin
          if (!enable_r) begin
            state_r <= ST_IDLE;
            busy_r  <= 1'b0;
          end else if (convEnd) begin
            state_r <= ST_IDLE;
            busy_r  <= 1'b0;
            code_r  <= sarCode;
          end else begin
            convCnt_r <= convCnt_r - 8'h01;
          end
        end
      endcase
    end
  end
  // ----------------------------------------------------------------------
  // Formatting and window detection.
  // ----------------------------------------------------------------------
  arf_formatter uFormat (
    .rawCode     (code_r),
    .diffMode    (diff_r),
    .leftJustify (ljst_r),
    .dataWord    (dataWord)
  );
  arf_window uWindow (
    .dataWord  (dataWord),
    .gtLimit   ({gtHi_r, gtLo_r}),
    .ltLimit   ({ltHi_r, ltLo_r}),
    .signedCmp (diff_r),
    .hit       (winHit)
  );
  // ----------------------------------------------------------------------
  // Software registers; hardware set wins over software clear.
  // ----------------------------------------------------------------------
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      enable_r    <= 1'b0;
      trackMode_r <= 1'b0;
      done_r      <= 1'b0;
      startSrc_r  <= `ARF_SRC_SW;
      win_r       <= 1'b0;
      ljst_r      <= 1'b0;
      diff_r      <= 1'b0;
      gtHi_r      <= `ARF_LIMIT_RST;
      gtLo_r      <= `ARF_LIMIT_RST;
      ltHi_r      <= `ARF_LIMIT_RST;
      ltLo_r      <= `ARF_LIMIT_RST;
    end else if (clkEn) begin
      if (wrCtl) begin
        enable_r    <= avWriteData[`ARF_CTL_EN];
        trackMode_r <= avWriteData[`ARF_CTL_TRK];
        startSrc_r  <= avWriteData[`ARF_CTL_SRC_HI:`ARF_CTL_SRC_LO];
        ljst_r      <= avWriteData[`ARF_CTL_LJST];
      end
      if (convEnd) begin
        done_r <= 1'b1;
      end else if (wrCtl) begin
        done_r <= avWriteData[`ARF_CTL_DONE];
      end
      if (newResult_r & winHit) begin
        win_r <= 1'b1;
      end else if (wrCtl) begin
        win_r <= avWriteData[`ARF_CTL_WIN];
      end
      if (avWrite & ack_r & avByteEnable[0]) begin
        if (regIdx == `ARF_IDX_GT_HI) begin
          gtHi_r <= avWriteData[7:0];
        end else if (regIdx == `ARF_IDX_GT_LO) begin
          gtLo_r <= avWriteData[7:0];
        end else if (regIdx == `ARF_IDX_LT_HI) begin
          ltHi_r <= avWriteData[7:0];
        end else if (regIdx == `ARF_IDX_LT_LO) begin
          ltLo_r <= avWriteData[7:0];
        end else if (regIdx == `ARF_IDX_CFG) begin
          diff_r <= avWriteData[`ARF_CFG_DIFF];
        end
      end
    end
  end
  // ----------------------------------------------------------------------
  // Read data.
  // ----------------------------------------------------------------------
  always @* begin
    if (regIdx == `ARF_IDX_CTRL) begin
      rdByte = {enable_r, trackMode_r, done_r, busy_r, startSrc_r, win_r, ljst_r};
    end else if (regIdx == `ARF_IDX_RES_HI) begin
      rdByte = dataWord[15:8];
    end else if (regIdx == `ARF_IDX_RES_LO) begin
      rdByte = dataWord[7:0];
    end else if (regIdx == `ARF_IDX_GT_HI) begin
      rdByte = gtHi_r;
    end else if (regIdx == `ARF_IDX_GT_LO) begin
      rdByte = gtLo_r;
    end else if (regIdx == `ARF_IDX_LT_HI) begin
      rdByte = ltHi_r;
    end else if (regIdx == `ARF_IDX_LT_LO) begin
      rdByte = ltLo_r;
    end else begin
      rdByte = {7'h00, diff_r};
    end
  end
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      avReadData <= 32'h00000000;
    end else if (clkEn) begin
      if (avRead & ~ack_r) begin
        avReadData <= {24'h000000, rdByte};
      end
    end
  end
endmodule // arf_adc_ctrl

// >>> verification/arf_adc_ctrl_sva.sv
// Assertion checker for the converter control block.
`timescale 1ns/10ps
module arf_adc_ctrl_sva (
  // Clock and reset
  input wire        mclk,
  input wire        reset,
  input wire        clkEn,
  // Register bus
  input wire [4:0]  avAddress,
  input wire        avRead,
  input wire        avWrite,
  input wire [31:0] avWriteData,
  input wire [3:0]  avByteEnable,
  input wire [31:0] avReadData,
  input wire        avWaitRequest,
  // Status
  input wire        converterPowerOn,
  input wire        windowCompareFlag,
  input wire        conversionDoneFlag
);
  // ---------------------------------------------------------------
  // Properties.
  // ---------------------------------------------------------------
  wire ctrlWr = avWrite && !avWaitRequest && avAddress[4:2] == 3'h0 && avByteEnable[0];
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  sequence convStart; ctrlWr && converterPowerOn && avWriteData[7:0] == 8'h90; endsequence
  sequence convRun; (!conversionDoneFlag) [*8] ##[7:9] conversionDoneFlag; endsequence
  chk_wait_once: assert property ((avRead || avWrite) && avWaitRequest && clkEn
    |=> !avWaitRequest) else $error("waitrequest held beyond one cycle");
  chk_read_upper: assert property (avRead && !avWaitRequest |-> avReadData[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  chk_power_follow: assert property (ctrlWr |=> converterPowerOn == $past(avWriteData[7]))
    else $error("power output does not follow enable bit");
  chk_win_sticky: assert property (windowCompareFlag && !(ctrlWr && !avWriteData[1])
    |=> windowCompareFlag) else $error("window flag dropped without software clear");
  chk_done_sticky: assert property (conversionDoneFlag && !(ctrlWr && !avWriteData[5])
    |=> conversionDoneFlag) else $error("done flag dropped without software clear");
  chk_done_power: assert property ($rose(conversionDoneFlag) && !$past(ctrlWr)
    |-> $past(converterPowerOn)) else $error("conversion completed while disabled");
  chk_win_after_done: assert property ($rose(windowCompareFlag) && !$past(ctrlWr)
    |-> $past(conversionDoneFlag)) else $error("window flag set without a result");
  chk_conv_time: assert property (convStart |=> convRun)
    else $error("conversion length wrong");
endmodule // arf_adc_ctrl_sva
bind arf_adc_ctrl arf_adc_ctrl_sva u_sva (.mclk(mclk), .reset(reset), .clkEn(clkEn),
  .avAddress(avAddress), .avRead(avRead), .avWrite(avWrite), .avWriteData(avWriteData),
  .avByteEnable(avByteEnable), .avReadData(avReadData), .avWaitRequest(avWaitRequest),
  .converterPowerOn(converterPowerOn), .windowCompareFlag(windowCompareFlag),
  .conversionDoneFlag(conversionDoneFlag));

// >>> verification/tb.sv
// Self-checking bench for the converter control block.
`timescale 1ns/10ps
module tb;
  // ---------------------------------------------------------------
  // Stimulus, rows and checking.
  // ---------------------------------------------------------------
  reg         mclk, reset, clkEn, avRead, avWrite, timerOverflow, externalConvertStart;
  reg  [4:0]  avAddress;
  reg  [31:0] avWriteData;
  reg  [3:0]  avByteEnable;
  reg  [11:0] sarCode;
  wire [31:0] avReadData;
  wire        avWaitRequest, converterPowerOn, windowCompareFlag, conversionDoneFlag;
  integer     err_count, cmp_count, i, n;
  reg  [7:0]  rv;
  reg  [67:0] r;
  reg  [67:0] rows [0:6];
  arf_adc_ctrl dut (.mclk(mclk), .reset(reset), .clkEn(clkEn), .avAddress(avAddress),
    .avRead(avRead), .avWrite(avWrite), .avWriteData(avWriteData),
    .avByteEnable(avByteEnable), .avReadData(avReadData), .avWaitRequest(avWaitRequest),
    .sarCode(sarCode), .externalConvertStart(externalConvertStart),
    .timerOverflow(timerOverflow), .converterPowerOn(converterPowerOn),
    .windowCompareFlag(windowCompareFlag), .conversionDoneFlag(conversionDoneFlag));
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task summarize;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  task tmo(input [63:0] nm);
    begin
      err_count = err_count + 1;
      $display("mismatch %0s expected completion seen timeout", nm);
      summarize;
    end
  endtask
  task chk(input [63:0] nm, input [7:0] e, input [7:0] g);
    begin
      cmp_count = cmp_count + 1;
      if (g !== e) begin
        err_count = err_count + 1;
        $display("mismatch %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task acc(input we, input [2:0] idx, input [7:0] wd, output [7:0] rd);
    reg w;
    begin
      @(posedge mclk);
      avAddress <= {idx, 2'b00};
      avWriteData <= {24'h0, wd};
      avWrite <= we;
      avRead <= !we;
      n = 0;
      w = 1'b1;
      while (w && n < 50) begin
        @(posedge mclk);
        w = (avWaitRequest !== 1'b0);
        rd = avReadData[7:0];
        n = n + 1;
      end
      if (w) tmo("waitreq");
      avWrite <= 1'b0;
      avRead <= 1'b0;
    end
  endtask
  initial begin
    // mode {diff,lj}, code, gt, lt, result hi, result lo, window flag
    rows[0] = 68'h0_150_0100_0200_01_50_1;
    rows[1] = 68'h0_250_0100_0200_02_50_0;
    rows[2] = 68'h0_250_0200_0100_02_50_1;
    rows[3] = 68'h1_fff_2000_1000_ff_f0_1;
    rows[4] = 68'h2_c00_0100_0200_fc_00_0;
    rows[5] = 68'h3_c00_0000_e000_c0_00_1;
    rows[6] = 68'h0_100_0100_0200_01_00_0;
    err_count = 0;
    cmp_count = 0;
    reset = 1'b1;
    clkEn = 1'b1;
    avRead = 1'b0;
    avWrite = 1'b0;
    avAddress = 5'h00;
    avWriteData = 32'h0;
    avByteEnable = 4'hf;
    sarCode = 12'h000;
    timerOverflow = 1'b0;
    externalConvertStart = 1'b0;
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    for (i = 0; i < 8; i = i + 1) begin
      acc(1'b0, i[2:0], 8'h00, rv);
      chk("resetval", 8'h00, rv);
    end
    $display("reset values done");
    for (i = 0; i < 7; i = i + 1) begin
      r = rows[i];
      sarCode <= r[63:52];
      acc(1'b1, 3'h7, {7'h0, r[65]}, rv);
      acc(1'b1, 3'h3, r[51:44], rv);
      acc(1'b1, 3'h4, r[43:36], rv);
      acc(1'b1, 3'h5, r[35:28], rv);
      acc(1'b1, 3'h6, r[27:20], rv);
      acc(1'b1, 3'h0, 8'h80, rv);
      acc(1'b1, 3'h0, {7'h48, r[64]}, rv);
      acc(1'b0, 3'h0, 8'h00, rv);
      chk("busy", {7'h48, r[64]}, rv);
      n = 0;
      while (conversionDoneFlag !== 1'b1 && n < 40) begin
        @(negedge mclk);
        n = n + 1;
      end
      if (n == 40) tmo("done");
      repeat (2) @(negedge mclk);
      chk("winpin", {7'h0, r[0]}, {7'h0, windowCompareFlag});
      acc(1'b0, 3'h0, 8'h00, rv);
      chk("ctrl", {6'h28, r[0], r[64]}, rv);
      acc(1'b0, 3'h1, 8'h00, rv);
      chk("reshi", r[19:12], rv);
      acc(1'b0, 3'h2, 8'h00, rv);
      chk("reslo", r[11:4], rv);
      $display("row %0d done", i);
    end
    acc(1'b1, 3'h1, 8'h5a, rv);
    acc(1'b0, 3'h1, 8'h00, rv);
    chk("resro", 8'h01, rv);
    acc(1'b1, 3'h0, 8'h00, rv);
    acc(1'b1, 3'h0, 8'h10, rv);
    repeat (20) @(negedge mclk);
    chk("offdone", 8'h00, {7'h0, conversionDoneFlag});
    acc(1'b0, 3'h0, 8'h00, rv);
    chk("offctrl", 8'h00, rv);
    acc(1'b1, 3'h0, 8'h80, rv);
    @(negedge mclk);
    chk("poweron", 8'h01, {7'h0, converterPowerOn});
    $display("enable test done");
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    @(negedge mclk);
    chk("poweroff", 8'h00, {7'h0, converterPowerOn});
    acc(1'b0, 3'h4, 8'h00, rv);
    chk("gtlo", 8'h00, rv);
    $display("mid-run reset done");
    summarize;
  end
endmodule // tb
